//--- pdreg_port_regs.v
// Purpose : eight 8-bit I/O ports, each with a direction register and a data register
// Assumes : single-cycle CPU byte bus with read and write strobes on clk_i
// Notes   : read data is registered, valid one cycle after the read strobe
//
// What this block does
// - direction register reads always return all ones
// - direction bit zero input, one output
// - bit ops on direction become read-modify-write
// - data address reads input pins for input bits
// - data registers at FFD4 to FFDC, none port4
// - direction registers at FFE4 to FFEC, none port4
// - output bits read back stored data value
// - output pins drive stored data bit level
`timescale 1ns/10ps
`include "pdreg_regs.vh"

module pdreg_port_regs (
    input  wire                                       clk_i,
    input  wire                                       rst_n_i,
    input  wire                                       clk_en_i,
    input  wire [`PDREG_ADDR_W-1:0]                   bus_addr_i,
    input  wire                                       bus_wr_i,
    input  wire                                       bus_rd_i,
    input  wire [`PDREG_DATA_W-1:0]                   bus_wdata_i,
    output reg  [`PDREG_DATA_W-1:0]                   bus_rdata_o,
    output reg                                        bus_rvalid_o,
    input  wire [`PDREG_NPORT*`PDREG_DATA_W-1:0]      pin_in_i,
    output reg  [`PDREG_NPORT*`PDREG_DATA_W-1:0]      pin_out_o,
    output reg  [`PDREG_NPORT*`PDREG_DATA_W-1:0]      pin_oe_o
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // ports 1,2,3,5..9 map to index 0..7; the hole for port four is skipped
    wire [`PDREG_ADDR_W-1:0]    data_ofs;
    wire [`PDREG_ADDR_W-1:0]    dir_ofs;
    wire                        in_data;
    wire                        in_dir;
    reg  [`PDREG_PORT_IDX_W-1:0] data_idx;
    reg  [`PDREG_PORT_IDX_W-1:0] dir_idx;

    assign data_ofs = bus_addr_i - `PDREG_OUT_DATA_BASE;
    assign dir_ofs  = bus_addr_i - `PDREG_DIR_CTRL_BASE;

    assign in_data = (bus_addr_i >= `PDREG_OUT_DATA_BASE) &&
                     (bus_addr_i <= `PDREG_OUT_DATA_LAST) &&
                     (data_ofs[3:0] != `PDREG_NO_PORT_OFS);
    assign in_dir  = (bus_addr_i >= `PDREG_DIR_CTRL_BASE) &&
                     (bus_addr_i <= `PDREG_DIR_CTRL_LAST) &&
                     (dir_ofs[3:0] != `PDREG_NO_PORT_OFS);

    always @* begin
        if (data_ofs[3:0] > `PDREG_NO_PORT_OFS) begin
            data_idx = data_ofs[2:0] - 3'h1;
        end else begin
            data_idx = data_ofs[2:0];
        end
        if (dir_ofs[3:0] > `PDREG_NO_PORT_OFS) begin
            dir_idx = dir_ofs[2:0] - 3'h1;
        end else begin
            dir_idx = dir_ofs[2:0];
        end
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    wire [`PDREG_NPORT*`PDREG_DATA_W-1:0] pin_level;

    // ------------------------------------------------------------------
    // per-port storage
    // ------------------------------------------------------------------
    reg  [`PDREG_DATA_W-1:0] dir_q  [0:`PDREG_NPORT-1];
    reg  [`PDREG_DATA_W-1:0] data_q [0:`PDREG_NPORT-1];
    wire [`PDREG_DATA_W-1:0] port_view [0:`PDREG_NPORT-1];

    genvar p;
    generate
        for (p = 0; p < `PDREG_NPORT; p = p + 1) begin : g_port
            pdreg_pin_sync u_sync (
                .clk_i    (clk_i),
                .rst_n_i  (rst_n_i),
                .clk_en_i (clk_en_i),
                .pin_i    (pin_in_i[p*`PDREG_DATA_W +: `PDREG_DATA_W]),
                .level_o  (pin_level[p*`PDREG_DATA_W +: `PDREG_DATA_W])
            );

            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    dir_q[p]  <= `PDREG_DIR_RST;
                    data_q[p] <= `PDREG_DATA_RST;
                end else if (clk_en_i) begin
                    // a whole byte always lands; bit ops arrive as full writes
                    if (bus_wr_i && in_dir && (dir_idx == p)) begin
                        dir_q[p] <= bus_wdata_i;
                    end
                    if (bus_wr_i && in_data && (data_idx == p)) begin
                        data_q[p] <= bus_wdata_i;
                    end
                end
            end

            // bit n of each register drives pin n
            assign port_view[p] = (dir_q[p] & data_q[p]) |
                                  (~dir_q[p] & pin_level[p*`PDREG_DATA_W +: `PDREG_DATA_W]);

            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    pin_out_o[p*`PDREG_DATA_W +: `PDREG_DATA_W] <= `PDREG_DATA_RST;
                    pin_oe_o[p*`PDREG_DATA_W +: `PDREG_DATA_W]  <= `PDREG_DIR_RST;
                end else if (clk_en_i) begin
                    pin_out_o[p*`PDREG_DATA_W +: `PDREG_DATA_W] <= data_q[p];
                    pin_oe_o[p*`PDREG_DATA_W +: `PDREG_DATA_W]  <= dir_q[p];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // direction registers cannot be read back, so software must keep its
    // own copy; a bit op on them turns every other input bit into an output
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_rdata_o  <= 8'h00;
            bus_rvalid_o <= 1'b0;
        end else if (clk_en_i) begin
            bus_rvalid_o <= bus_rd_i;
            if (bus_rd_i) begin
                if (in_data) begin
                    bus_rdata_o <= port_view[data_idx];
                end else if (in_dir) begin
                    bus_rdata_o <= `PDREG_DIR_READ_VAL;
                end else begin
                    bus_rdata_o <= `PDREG_UNMAPPED_VAL;
                end
            end
        end
    end

endmodule

//--- pdreg_regs.vh
// Purpose : address map and reset values of the port direction/data block
// Assumes : 16-bit byte address bus, 8-bit data
// Notes   : port four has no registers in either bank
`ifndef PDREG_REGS_VH
`define PDREG_REGS_VH

// ----------------------------------------------------------------------
// address map
// ----------------------------------------------------------------------
`define PDREG_ADDR_W          16
`define PDREG_DATA_W          8
`define PDREG_NPORT           8
`define PDREG_PORT_IDX_W      3
`define PDREG_OUT_DATA_BASE   16'hFFD4
`define PDREG_OUT_DATA_LAST   16'hFFDC
`define PDREG_DIR_CTRL_BASE   16'hFFE4
`define PDREG_DIR_CTRL_LAST   16'hFFEC
`define PDREG_NO_PORT_OFS     4'h3
`define PDREG_PORT1_OUT_DATA  16'hFFD4
`define PDREG_PORT2_OUT_DATA  16'hFFD5
`define PDREG_PORT3_OUT_DATA  16'hFFD6
`define PDREG_PORT5_OUT_DATA  16'hFFD8
`define PDREG_PORT6_OUT_DATA  16'hFFD9
`define PDREG_PORT7_OUT_DATA  16'hFFDA
`define PDREG_PORT8_OUT_DATA  16'hFFDB
`define PDREG_PORT9_OUT_DATA  16'hFFDC
`define PDREG_PORT1_DIR_CTRL  16'hFFE4
`define PDREG_PORT2_DIR_CTRL  16'hFFE5
`define PDREG_PORT3_DIR_CTRL  16'hFFE6
`define PDREG_PORT5_DIR_CTRL  16'hFFE8
`define PDREG_PORT6_DIR_CTRL  16'hFFE9
`define PDREG_PORT7_DIR_CTRL  16'hFFEA
`define PDREG_PORT8_DIR_CTRL  16'hFFEB
`define PDREG_PORT9_DIR_CTRL  16'hFFEC

// ----------------------------------------------------------------------
// values
// ----------------------------------------------------------------------
`define PDREG_DIR_READ_VAL    8'hFF
`define PDREG_DIR_RST         8'h00
`define PDREG_DATA_RST        8'h00
`define PDREG_UNMAPPED_VAL    8'hFF

`endif

//--- pdreg_pin_sync.v
// Purpose : three-stage synchroniser for one 8-bit group of port pins
// Assumes : pins are asynchronous to clk_i
// Notes   : output moves only once stages two and three agree
`timescale 1ns/10ps
`include "pdreg_regs.vh"

module pdreg_pin_sync (
    input  wire                      clk_i,
    input  wire                      rst_n_i,
    input  wire                      clk_en_i,
    input  wire [`PDREG_DATA_W-1:0]  pin_i,
    output reg  [`PDREG_DATA_W-1:0]  level_o
);

    reg [`PDREG_DATA_W-1:0] s1_q;
    reg [`PDREG_DATA_W-1:0] s2_q;
    reg [`PDREG_DATA_W-1:0] s3_q;

    genvar b;
    generate
        for (b = 0; b < `PDREG_DATA_W; b = b + 1) begin : g_bit
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    s1_q[b]    <= 1'b0;
                    s2_q[b]    <= 1'b0;
                    s3_q[b]    <= 1'b0;
                    level_o[b] <= 1'b0;
                end else if (clk_en_i) begin
                    s1_q[b] <= pin_i[b];
                    s2_q[b] <= s1_q[b];
                    s3_q[b] <= s2_q[b];
                    // a single disagreeing sample does not move the level
                    if (s2_q[b] == s3_q[b]) begin
                        level_o[b] <= s3_q[b];
                    end
                end
            end
        end
    endgenerate

endmodule

//--- pdreg_port_regs_monitor.sv
// Purpose : bus and pin checks on the port register block
// Assumes : one clock, asynchronous active-low reset
// Notes   : port three stands in for every port in the pin-level checks
`timescale 1ns/10ps
module pdreg_port_regs_monitor (
    input wire        clk_i,
    input wire        rst_n_i,
    input wire        clk_en_i,
    input wire [15:0] bus_addr_i,
    input wire        bus_wr_i,
    input wire        bus_rd_i,
    input wire [7:0]  bus_wdata_i,
    input wire [7:0]  bus_rdata_o,
    input wire        bus_rvalid_o,
    input wire [63:0] pin_in_i,
    input wire [63:0] pin_out_o,
    input wire [63:0] pin_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_wr(a);
        (bus_wr_i && clk_en_i && bus_addr_i == a) ##1 (clk_en_i && !bus_wr_i);
    endsequence
    // pins held long enough for the synchroniser to settle before the read
    sequence s_quiet_rd;
        ($stable(pin_in_i[23:16]) && clk_en_i)[*6] ##0 (bus_rd_i && !bus_wr_i
            && bus_addr_i == 16'hFFD6 && pin_oe_o[23:16] == 8'h00);
    endsequence
    a_read_valid: assert property (bus_rd_i && clk_en_i |=> bus_rvalid_o)
        else $error("read strobe gave no valid");
    a_valid_cause: assert property (bus_rvalid_o |-> $past(bus_rd_i))
        else $error("valid without a read");
    a_dir_ones: assert property (bus_rd_i && clk_en_i && bus_addr_i[15:4] == 12'hFFE |=>
        bus_rdata_o == 8'hFF) else $error("direction read not all ones");
    a_gap_ones: assert property (bus_rd_i && clk_en_i && bus_addr_i == 16'hFFD7 |=>
        bus_rdata_o == 8'hFF) else $error("gap read not all ones");
    a_oe_follows: assert property (s_wr(16'hFFE6) |=> pin_oe_o[23:16] == $past(bus_wdata_i, 2))
        else $error("direction write not on enables");
    a_out_follows: assert property (s_wr(16'hFFD6) |=> pin_out_o[23:16] == $past(bus_wdata_i, 2))
        else $error("data write not on pins");
    a_out_readback: assert property (bus_rd_i && clk_en_i && !bus_wr_i && bus_addr_i == 16'hFFD6 |=>
        ((bus_rdata_o ^ pin_out_o[23:16]) & pin_oe_o[23:16]) == 8'h00) else $error("output bit readback");
    a_pin_read: assert property (s_quiet_rd |=> bus_rdata_o == $past(pin_in_i[23:16]))
        else $error("input bits not pin level");
endmodule
bind pdreg_port_regs pdreg_port_regs_monitor MON (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i), .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
    .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .bus_rvalid_o(bus_rvalid_o),
    .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));

//--- pdreg_pin_model.sv
// Purpose : external circuitry on the port pins
// Assumes : outside drivers are weak and yield to a driving port bit
// Notes   : no contention modelled, so read-back of output bits equals data
`timescale 1ns/10ps
module pdreg_pin_model (
    input  wire [63:0] pin_out_i,
    input  wire [63:0] pin_oe_i,
    input  wire [63:0] ext_i,
    output wire [63:0] level_o
);
    assign level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_i);
endmodule

//--- pdreg_port_regs_tb.sv
// Purpose : self-checking bench for the port register block
// Assumes : pins resolved by the pin model, clock enable held high except while t_freeze_reset drives it low
// Notes   : expected values come from the address map and fixed patterns
`timescale 1ns/10ps
module pdreg_port_regs_tb;
    reg         clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, en = 1'b1;
    reg  [15:0] addr = 16'h0000, k;
    reg  [7:0]  wdata = 8'h00, dv, pv;
    reg  [63:0] ext = 64'h0123456789ABCDEF;
    wire [7:0]  rdata;
    wire        rvalid;
    wire [63:0] pins, pout, poe;
    integer     errors = 0, checks_done = 0;
    always #2.5 clk = ~clk;
    pdreg_port_regs DUT (.clk_i(clk), .rst_n_i(rst_n), .clk_en_i(en), .bus_addr_i(addr),
        .bus_wr_i(wr), .bus_rd_i(rd), .bus_wdata_i(wdata), .bus_rdata_o(rdata),
        .bus_rvalid_o(rvalid), .pin_in_i(pins), .pin_out_o(pout), .pin_oe_o(poe));
    pdreg_pin_model PINS (.pin_out_i(pout), .pin_oe_i(poe), .ext_i(ext), .level_o(pins));
    task chk(input string n, input logic [63:0] s, input logic [63:0] e);
        checks_done = checks_done + 1;
        if (s !== e) begin
            errors = errors + 1;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task bus_wr(input [15:0] a, input [7:0] d);
        @(negedge clk) begin addr = a; wdata = d; wr = 1'b1; end
        @(negedge clk) wr = 1'b0;
    endtask
    // valid and data are both judged in the one cycle that valid stands
    task bus_rd(input [15:0] a, input [7:0] e, input string n);
        @(negedge clk) begin addr = a; rd = 1'b1; end
        @(negedge clk) rd = 1'b0;
        chk(n, {55'h0, rvalid, rdata}, {55'h0, 1'b1, e});
    endtask
    // port four has no registers, so later ports skip one address
    function [15:0] pa(input [15:0] base);
        pa = base + k + {15'h0, k > 16'h0002};
    endfunction
    task t_reset_inputs;
        chk("oe after reset", poe, 64'h0);
        repeat (8) @(negedge clk);
        for (k = 0; k < 8; k = k + 1) bus_rd(pa(16'hFFD4), ext[8*k+:8], "pin read");
    endtask
    task t_each_port;
        for (k = 0; k < 8; k = k + 1) begin
            dv = 8'hF0 | k[7:0];
            pv = 8'h5A ^ k[7:0];
            bus_wr(pa(16'hFFE4), dv);
            bus_wr(pa(16'hFFD4), pv);
            repeat (6) @(negedge clk);
            chk("oe", {56'h0, poe[8*k+:8]}, {56'h0, dv});
            chk("out", {56'h0, pout[8*k+:8]}, {56'h0, pv});
            bus_rd(pa(16'hFFE4), 8'hFF, "dir read");
            bus_rd(pa(16'hFFD4), (dv & pv) | (~dv & ext[8*k+:8]), "mixed read");
        end
    endtask
    task t_gaps;
        bus_rd(16'hFFD7, 8'hFF, "gap data");
        bus_rd(16'hFFE7, 8'hFF, "gap dir");
        bus_wr(16'hFFD7, 8'h00);
        repeat (2) @(negedge clk);
        chk("gap write", {48'h0, pout[31:16]}, 64'h5958);
    endtask
    task t_bit_clear;
        bus_wr(16'hFFE6, 8'h3F);
        bus_rd(16'hFFE6, 8'hFF, "rmw read");
        bus_wr(16'hFFE6, rdata & 8'hFE);
        repeat (2) @(negedge clk);
        chk("rmw oe", {56'h0, poe[23:16]}, 64'hFE);
        bus_wr(16'hFFE6, 8'h3F & 8'hFE);
        repeat (2) @(negedge clk);
        chk("shadow oe", {56'h0, poe[23:16]}, 64'h3E);
    endtask
    // a low enable must hold the port one data register; a mid-run reset clears outputs
    task t_freeze_reset;
        @(negedge clk) en = 1'b0;
        bus_wr(16'hFFD4, 8'hC3);
        repeat (2) @(negedge clk);
        chk("frozen out", {56'h0, pout[7:0]}, 64'h5A);
        en = 1'b1;
        repeat (2) @(negedge clk);
        chk("thawed out", {56'h0, pout[7:0]}, 64'h5A);
        rst_n = 1'b0;
        @(negedge clk);
        chk("reset oe", poe, 64'h0);
        chk("reset out", pout, 64'h0);
        chk("reset rd", {55'h0, rvalid, rdata}, 64'h0);
        rst_n = 1'b1;
        repeat (8) @(negedge clk);
        bus_rd(16'hFFD6, ext[23:16], "pin after reset");
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        t_reset_inputs;
        t_each_port;
        t_gaps;
        t_bit_clear;
        t_freeze_reset;
        give_verdict;
    end
    initial begin
        #20000;
        errors = errors + 1;
        give_verdict;
    end
endmodule
